// ---- crb_pkg.sv ----
/*
 * Shared constants and carrier types for the core register bank.
 * Assumes a CPU execution unit that issues one operation per enabled
 * clock and a reset controller that reports the cause of each reset.
 */
package crb_pkg;

	// ------------------------------------------------------------------
	// Address map
	// ------------------------------------------------------------------
	localparam int         ADDR_W          = 12;
	localparam int         OFFS_W          = 7;
	localparam int         CORE_COUNT      = 12;
	localparam logic [6:0] OFFS_LAST       = 7'h0b;
	localparam logic [6:0] MIRROR_BASE     = 7'h00;
	localparam logic [3:0] IDX_INDIRECT0   = 4'h0;
	localparam logic [3:0] IDX_INDIRECT1   = 4'h1;
	localparam logic [3:0] IDX_PC_LOW      = 4'h2;
	localparam logic [3:0] IDX_STATUS      = 4'h3;
	localparam logic [3:0] IDX_PTR0_LOW    = 4'h4;
	localparam logic [3:0] IDX_PTR0_HIGH   = 4'h5;
	localparam logic [3:0] IDX_PTR1_LOW    = 4'h6;
	localparam logic [3:0] IDX_PTR1_HIGH   = 4'h7;
	localparam logic [3:0] IDX_BANK_SEL    = 4'h8;
	localparam logic [3:0] IDX_ACCUM       = 4'h9;
	localparam logic [3:0] IDX_PC_LATCH    = 4'ha;
	localparam logic [3:0] IDX_INT_CTRL    = 4'hb;

	// ------------------------------------------------------------------
	// Status field positions and reset values
	// ------------------------------------------------------------------
	localparam int         BIT_EXPIRY      = 4;
	localparam int         BIT_SLEEP       = 3;
	localparam int         BIT_ZERO        = 2;
	localparam int         BIT_NIBBLE      = 1;
	localparam int         BIT_CARRY       = 0;
	localparam logic       RST_EXPIRY      = 1'b1;
	localparam logic       RST_SLEEP       = 1'b1;
	localparam logic       RST_ARITH       = 1'b0;
	localparam logic [7:0] RST_CORE        = 8'h00;

	// ------------------------------------------------------------------
	// Operations and carriers
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_MOVE   = 4'h0,  // Pass operand b, no flag touched
		OP_PASSZ  = 4'h1,  // Pass operand b, zero flag from result
		OP_AND    = 4'h2,
		OP_OR     = 4'h3,
		OP_XOR    = 4'h4,
		OP_ADD    = 4'h5,
		OP_SUB    = 4'h6,  // a minus b
		OP_ROTL   = 4'h7,
		OP_ROTR   = 4'h8,
		OP_CLEAR  = 4'h9
	} crb_op_t;

	typedef struct packed {
		logic                valid;
		crb_op_t             op;
		logic [7:0]          a;
		logic [7:0]          b;
		logic [ADDR_W-1:0]   addr;
		logic                to_file;
	} crb_exec_t;

	typedef struct packed {
		logic                kick;
		logic                sleep;
		logic                expire;
	} crb_evt_t;

endpackage : crb_pkg

// ---- crb_core_regs.sv ----
/*
 * Core register bank with the processor status register and flag logic.
 * Assumes the execution unit presents one operation per enabled clock,
 * reads the result one clock later and keeps to flag-neutral
 * instructions when it only means to alter status bits.
 */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Twelve core registers in every data bank
// - Offsets 00h-0Bh and 80h-8Bh decode them
// - Flag instructions to status suppress data write
// - Expiry and sleep flags ignore all writes
// - Clearing status zeroes top, sets zero flag
// - Status bits seven to five read zero
// - Bit four set by power/kick/sleep, cleared by expiry
// - Bit three set by power/kick, cleared by sleep
// - Bit two reports a zero result
// - Bit one is carry out of bit three
// - Bit zero is carry out of bit seven
// - Subtract adds complement; flags mean no borrow
// - Rotates load carry with shifted-out bit
// - Power reset sets power flags, clears arithmetic
module crb_core_regs (
	input  wire logic                              REF_CLK,
	input  wire logic                              RST_B,
	input  wire logic                              CLK_EN,
	input  wire logic                              SOFT_RST,
	input  wire crb_pkg::crb_evt_t                 EVT,
	input  wire crb_pkg::crb_exec_t                EXEC,
	input  wire logic                              RD_EN,
	input  wire logic [crb_pkg::ADDR_W-1:0]        RD_ADDR,
	output logic [7:0]                             RD_DATA,
	output logic                                   RD_HIT,
	output logic [7:0]                             RESULT,
	output logic [7:0]                             STATUS_Q,
	output logic [7:0]                             BANK_Q,
	output logic [7:0]                             ACCUM_Q
);

	// ------------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------------

	// Only the in-bank offset matters, so every bank and mirror half
	// lands on the same register
	function automatic logic core_hit(input logic [crb_pkg::ADDR_W-1:0] addr);
		logic [crb_pkg::OFFS_W-1:0] low;
		low = addr[crb_pkg::OFFS_W-1:0];
		core_hit = (low <= crb_pkg::OFFS_LAST);
	endfunction : core_hit

	// Register index of a hit; only the low four offset bits are used, so the mirror bit is ignored
	function automatic logic [3:0] core_idx(input logic [crb_pkg::ADDR_W-1:0] addr);
		core_idx = addr[3:0];
	endfunction : core_idx

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	logic [7:0]  core_reg [crb_pkg::CORE_COUNT];
	logic        expiry_flag;
	logic        sleep_flag;
	logic        zero_flag;
	logic        nibble_carry_flag;
	logic        carry_flag;

	// ------------------------------------------------------------------
	// Arithmetic and flag results
	// ------------------------------------------------------------------
	logic        is_sub;
	logic        is_add;
	logic [7:0]  b_eff;
	logic [8:0]  add_sum;
	logic [4:0]  nib_sum;
	logic [7:0]  res;
	logic        upd_z;
	logic        upd_dc;
	logic        upd_c;
	logic        res_c;
	logic        any_upd;

	// Subtraction reuses the adder with the complemented operand and a
	// carry in, so carry out means no borrow
	assign is_sub  = (EXEC.op == crb_pkg::OP_SUB);
	assign is_add  = (EXEC.op == crb_pkg::OP_ADD) || is_sub;
	assign b_eff   = is_sub ? ~EXEC.b : EXEC.b;
	assign add_sum = {1'b0, EXEC.a} + {1'b0, b_eff} + {8'h00, is_sub};
	assign nib_sum = {1'b0, EXEC.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, is_sub};

	// Result selection
	assign res =
		is_add                          ? add_sum[7:0] :
		(EXEC.op == crb_pkg::OP_AND)    ? (EXEC.a & EXEC.b) :
		(EXEC.op == crb_pkg::OP_OR)     ? (EXEC.a | EXEC.b) :
		(EXEC.op == crb_pkg::OP_XOR)    ? (EXEC.a ^ EXEC.b) :
		(EXEC.op == crb_pkg::OP_ROTL)   ? {EXEC.a[6:0], carry_flag} :
		(EXEC.op == crb_pkg::OP_ROTR)   ? {carry_flag, EXEC.a[7:1]} :
		(EXEC.op == crb_pkg::OP_CLEAR)  ? 8'h00 :
		EXEC.b;

	// Which flags this operation owns
	assign upd_z   = is_add
		|| (EXEC.op == crb_pkg::OP_PASSZ)
		|| (EXEC.op == crb_pkg::OP_AND)
		|| (EXEC.op == crb_pkg::OP_OR)
		|| (EXEC.op == crb_pkg::OP_XOR)
		|| (EXEC.op == crb_pkg::OP_CLEAR);
	assign upd_dc  = is_add;
	assign upd_c   = is_add
		|| (EXEC.op == crb_pkg::OP_ROTL)
		|| (EXEC.op == crb_pkg::OP_ROTR);
	assign any_upd = upd_z || upd_dc || upd_c;

	// Carry source: adder top bit, or the bit a rotate pushes out
	assign res_c =
		(EXEC.op == crb_pkg::OP_ROTL) ? EXEC.a[7] :
		(EXEC.op == crb_pkg::OP_ROTR) ? EXEC.a[0] :
		add_sum[8];

	// ------------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------------
	logic        step;
	logic        wr_core;
	logic [3:0]  wr_idx;
	logic        wr_status;
	logic        status_data_wr;

	assign step           = CLK_EN;
	assign wr_core        = EXEC.valid && EXEC.to_file && core_hit(EXEC.addr);
	assign wr_idx         = core_idx(EXEC.addr);
	assign wr_status      = wr_core && (wr_idx == crb_pkg::IDX_STATUS);
	// A flag-owning operation aimed at status loses its data write to
	// the arithmetic bits, so the stored value may differ from intent
	assign status_data_wr = wr_status && !any_upd;

	// ------------------------------------------------------------------
	// Status next values
	// ------------------------------------------------------------------
	logic        exec_go;
	logic        next_zero;
	logic        next_nibble;
	logic        next_carry;
	logic        next_expiry;
	logic        next_sleep;

	assign exec_go     = EXEC.valid;

	// Flag results win over data; data only reaches flags when the
	// operation owns none of them
	assign next_zero   =
		(exec_go && upd_z)  ? (res == 8'h00) :
		status_data_wr      ? EXEC.b[crb_pkg::BIT_ZERO] :
		zero_flag;
	assign next_nibble =
		(exec_go && upd_dc) ? nib_sum[4] :
		status_data_wr      ? EXEC.b[crb_pkg::BIT_NIBBLE] :
		nibble_carry_flag;
	assign next_carry  =
		(exec_go && upd_c)  ? res_c :
		status_data_wr      ? EXEC.b[crb_pkg::BIT_CARRY] :
		carry_flag;

	// Hardware events only; register writes never reach these two.
	// An expiry in the same cycle as a kick is taken as the expiry,
	// since a missed time-out is worse than a missed kick.
	assign next_expiry =
		EVT.expire              ? 1'b0 :
		(EVT.kick || EVT.sleep) ? 1'b1 :
		expiry_flag;
	assign next_sleep  =
		EVT.kick  ? 1'b1 :
		EVT.sleep ? 1'b0 :
		sleep_flag;

	// ------------------------------------------------------------------
	// Status register
	// ------------------------------------------------------------------

	// Power-on and brown-out come in on the asynchronous reset; a soft
	// reset keeps the arithmetic flags and lets events set the cause
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			expiry_flag       <= crb_pkg::RST_EXPIRY;
			sleep_flag        <= crb_pkg::RST_SLEEP;
			zero_flag         <= crb_pkg::RST_ARITH;
			nibble_carry_flag <= crb_pkg::RST_ARITH;
			carry_flag        <= crb_pkg::RST_ARITH;
		end else if (step) begin
			expiry_flag       <= next_expiry;
			sleep_flag        <= next_sleep;
			if (!SOFT_RST) begin
				zero_flag         <= next_zero;
				nibble_carry_flag <= next_nibble;
				carry_flag        <= next_carry;
			end
		end
	end

	// ------------------------------------------------------------------
	// Plain core registers
	// ------------------------------------------------------------------

	// One flop set per index; every bank alias writes the same storage
	genvar gi;
	generate
		for (gi = 0; gi < crb_pkg::CORE_COUNT; gi++) begin : g_core
			localparam logic [3:0] IDX = 4'(gi);
			if (IDX == crb_pkg::IDX_STATUS) begin : g_stat
				// Status lives in the flag flops above
				assign core_reg[gi] = {3'b000, expiry_flag, sleep_flag,
					zero_flag, nibble_carry_flag, carry_flag};
			end else begin : g_plain
				logic sel;
				assign sel = wr_core && (wr_idx == IDX);
				always_ff @(posedge REF_CLK or negedge RST_B) begin
					if (!RST_B) begin
						core_reg[gi] <= crb_pkg::RST_CORE;
					end else if (step) begin
						if (SOFT_RST) begin
							core_reg[gi] <= crb_pkg::RST_CORE;
						end else if (sel) begin
							core_reg[gi] <= res;
						end
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------
	logic        rd_hit;
	logic [3:0]  rd_idx;
	logic [7:0]  rd_word;

	// Reads take the stored value, before any write in the same cycle
	assign rd_hit  = RD_EN && core_hit(RD_ADDR);
	assign rd_idx  = core_idx(RD_ADDR);
	assign rd_word = rd_hit ? core_reg[rd_idx] : 8'h00;

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			RD_DATA <= 8'h00;
			RD_HIT  <= 1'b0;
		end else if (step) begin
			RD_DATA <= rd_word;
			RD_HIT  <= rd_hit;
		end
	end

	// ------------------------------------------------------------------
	// Registered views for the execution unit
	// ------------------------------------------------------------------

	// Mirrors are one cycle behind the storage so every output is a flop
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			RESULT   <= 8'h00;
			STATUS_Q <= {3'b000, crb_pkg::RST_EXPIRY, crb_pkg::RST_SLEEP, 3'b000};
			BANK_Q   <= crb_pkg::RST_CORE;
			ACCUM_Q  <= crb_pkg::RST_CORE;
		end else if (step) begin
			if (exec_go) begin
				RESULT <= res;
			end
			STATUS_Q <= core_reg[crb_pkg::IDX_STATUS];
			BANK_Q   <= core_reg[crb_pkg::IDX_BANK_SEL];
			ACCUM_Q  <= core_reg[crb_pkg::IDX_ACCUM];
		end
	end

endmodule : crb_core_regs

`default_nettype wire

// ---- crb_core_regs_chk.sv ----
/* Concurrent checks on the core register bank ports.
   Assumes one clock domain; bound to every instance of the bank. */
`timescale 1ns/1ps
`default_nettype none
module crb_core_regs_chk (
	input wire logic               REF_CLK,
	input wire logic               RST_B,
	input wire logic               CLK_EN,
	input wire crb_pkg::crb_evt_t  EVT,
	input wire crb_pkg::crb_exec_t EXEC,
	input wire logic               RD_EN,
	input wire logic [11:0]        RD_ADDR,
	input wire logic [7:0]         RD_DATA,
	input wire logic               RD_HIT,
	input wire logic [7:0]         RESULT,
	input wire logic [7:0]         STATUS_Q
);
	// ----------------------------
	// Decode helpers
	// ----------------------------
	// Address bit 7 is the mirror half and is ignored
	wire core = RD_ADDR[6:4] == 3'h0 && RD_ADDR[3:0] <= 4'hb;
	wire rd = RD_EN && CLK_EN;
	wire op = EXEC.valid && CLK_EN;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);

	a_top_bits_zero: assert property (STATUS_Q[7:5] == 3'h0)
		else $error("status top bits not zero");
	a_reset_value: assert property (disable iff (1'b0) !RST_B |=> STATUS_Q == 8'h18)
		else $error("status reset value wrong");
	a_miss_reads_zero: assert property (rd && !core |=> RD_DATA == 8'h00 && !RD_HIT)
		else $error("non-core read not zero");
	// Read path and status output sample the same stored value
	a_status_read: assert property (rd && core && RD_ADDR[3:0] == 4'h3 |=> RD_HIT && RD_DATA == STATUS_Q)
		else $error("status read mismatch");
	a_clear_sets_zero: assert property (op && EXEC.op == crb_pkg::OP_CLEAR |=> RESULT == 8'h00 ##1 STATUS_Q[2])
		else $error("clear did not set zero flag");
	a_expiry_clears: assert property (CLK_EN && EVT.expire |-> ##2 !STATUS_Q[4])
		else $error("expiry flag not cleared");
	a_kick_sets: assert property (CLK_EN && EVT.kick && !EVT.expire |-> ##2 STATUS_Q[4:3] == 2'b11)
		else $error("kick did not set power flags");
	a_sleep_clears: assert property (CLK_EN && EVT.sleep && !EVT.kick |-> ##2 !STATUS_Q[3])
		else $error("sleep flag not cleared");
	a_zero_tracks: assert property (op && EXEC.op inside {crb_pkg::OP_AND, crb_pkg::OP_XOR} |=> ##1 STATUS_Q[2] == ($past(RESULT) == 8'h00))
		else $error("zero flag wrong");
endmodule : crb_core_regs_chk
bind crb_core_regs crb_core_regs_chk u_chk (.REF_CLK(REF_CLK), .RST_B(RST_B), .CLK_EN(CLK_EN),
	.EVT(EVT), .EXEC(EXEC), .RD_EN(RD_EN), .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA),
	.RD_HIT(RD_HIT), .RESULT(RESULT), .STATUS_Q(STATUS_Q));
`default_nettype wire

// ---- crb_cpu_model.sv ----
/* Execution-unit partner: issues operations and reads to the bank.
   Assumes each task is entered just after a rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
module crb_cpu_model (
	input  wire logic               ref_clk,
	output var crb_pkg::crb_exec_t exec_bus,
	output var logic               rd_en,
	output var logic [11:0]        rd_addr
);
	// ----------------------------
	// Bus tasks
	// ----------------------------
	// Quiet bus from time zero
	initial begin
		exec_bus = '0;
		rd_en = 1'b0;
		rd_addr = 12'h000;
	end
	// Stale operand a and the address are scrambled so ignoring valid shows up
	task automatic drop;
		exec_bus.valid = 1'b0;
		exec_bus.a = ~exec_bus.a;
		exec_bus.addr = ~exec_bus.addr;
	endtask : drop
	// One operation, held until the taking edge has passed
	task automatic run_op(input crb_pkg::crb_op_t o, input logic [7:0] a, b, input logic [11:0] ad);
		exec_bus = '{valid: 1'b1, op: o, a: a, b: b, addr: ad, to_file: 1'b1};
		rd_en = 1'b0;
		@(posedge ref_clk);
		#1;
	endtask : run_op
	task automatic run_rd(input logic [11:0] ad);
		drop();
		rd_en = 1'b1;
		rd_addr = ad;
		@(posedge ref_clk);
		#1;
	endtask : run_rd
	task automatic idle;
		drop();
		rd_en = 1'b0;
		rd_addr = ~rd_addr;
		@(posedge ref_clk);
		#1;
	endtask : idle
endmodule : crb_cpu_model
`default_nettype wire

// ---- crb_core_regs_tb.sv ----
/* Self-checking bench for the core register bank against a queue-free
   integer model. Assumes the partner model and bound checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin bad_count++; \
	$display("ERROR %s exp %h got %h", nm, e, s); end end
module crb_core_regs_tb;
	logic                 REF_CLK = 1'b0;
	logic                 RST_B = 1'b0;
	logic                 soft_rst = 1'b0;
	logic                 clk_en = 1'b1;
	crb_pkg::crb_evt_t    evt = '0;
	crb_pkg::crb_exec_t   exec_bus;
	logic                 rd_en, rd_hit;
	logic [11:0]          rd_addr, ad;
	logic [7:0]           rd_data, result, status_q, bank_q, accum_q, m_res, a, b;
	logic [7:0]           m_reg [12];
	logic [4:0]           m_st;
	int                   bad_count = 0, n_checks = 0, op;
	// ----------------------------
	// Clock, partner and design
	// ----------------------------
	always #20 REF_CLK = ~REF_CLK;
	crb_cpu_model u_cpu (.ref_clk(REF_CLK), .exec_bus(exec_bus), .rd_en(rd_en), .rd_addr(rd_addr));
	crb_core_regs u_dut (.REF_CLK(REF_CLK), .RST_B(RST_B), .CLK_EN(clk_en), .SOFT_RST(soft_rst),
		.EVT(evt), .EXEC(exec_bus), .RD_EN(rd_en), .RD_ADDR(rd_addr), .RD_DATA(rd_data),
		.RD_HIT(rd_hit), .RESULT(result), .STATUS_Q(status_q), .BANK_Q(bank_q), .ACCUM_Q(accum_q));
	// Reference ALU and store; only a plain move may write status data
	task automatic model_op(input int o, input logic [7:0] x, y, input logic [11:0] d);
		logic [8:0] s;
		logic [4:0] n;
		s = {1'b0, x} + {1'b0, y};
		n = {1'b0, x[3:0]} + {1'b0, y[3:0]};
		m_res = (o == 2) ? x & y : (o == 3) ? x | y : (o == 4) ? x ^ y : y;
		if (o == 6) s = {1'b0, x} + {1'b0, ~y} + 9'h001;
		if (o == 6) n = {1'b0, x[3:0]} + {1'b0, ~y[3:0]} + 5'h01;
		if (o == 5 || o == 6) m_res = s[7:0];
		if (o == 7) {s[8], m_res} = {x, m_st[0]};
		if (o == 8) {m_res, s[8]} = {m_st[0], x};
		if (o == 9) m_res = 8'h00;
		if (o inside {[1:6], 9}) m_st[2] = m_res == 8'h00;
		if (o inside {5, 6}) m_st[1:0] = {n[4], s[8]};
		if (o inside {7, 8}) m_st[0] = s[8];
		if (d[6:4] == 3'h0 && d[3:0] < 4'hc && d[3:0] != 4'h3) m_reg[d[3:0]] = m_res;
		if (d[6:4] == 3'h0 && d[3:0] == 4'h3 && o == 0) m_st[2:0] = m_res[2:0];
	endtask : model_op
	function automatic logic [7:0] m_read(input logic [11:0] d);
		if (d[6:4] != 3'h0 || d[3:0] > 4'hb) return 8'h00;
		return (d[3:0] == 4'h3) ? {3'h0, m_st} : m_reg[d[3:0]];
	endfunction : m_read
	task automatic chk_rd(input logic [11:0] d);
		u_cpu.run_rd(d);
		`CHK("rd_data", m_read(d), rd_data)
		`CHK("rd_hit", d[6:4] == 3'h0 && d[3:0] < 4'hc, rd_hit)
		`CHK("status", {3'h0, m_st}, status_q)
		`CHK("bank", m_reg[8], bank_q)
		`CHK("accum", m_reg[9], accum_q)
	endtask : chk_rd
	// Operation, result compare, then a checked read at the caller's read address
	task automatic step(input int o, input logic [7:0] x, y, input logic [11:0] d, r);
		model_op(o, x, y, d);
		u_cpu.run_op(crb_pkg::crb_op_t'(o), x, y, d);
		`CHK("result", m_res, result)
		chk_rd(r);
	endtask : step
	task automatic ev(input logic k, s, x);
		evt = '{kick: k, sleep: s, expire: x};
		@(posedge REF_CLK);
		#1;
		evt = '0;
		if (x) m_st[4] = 1'b0; else if (k || s) m_st[4] = 1'b1;
		if (k) m_st[3] = 1'b1; else if (s) m_st[3] = 1'b0;
		chk_rd(12'h003);
	endtask : ev
	task automatic do_reset(input logic hard);
		u_cpu.idle();
		if (hard) RST_B = 1'b0; else soft_rst = 1'b1;
		@(posedge REF_CLK);
		#1;
		RST_B = 1'b1;
		soft_rst = 1'b0;
		foreach (m_reg[i]) m_reg[i] = 8'h00;
		if (hard) m_st = 5'h18;
	endtask : do_reset
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : final_report
	// Watchdog well past the expected run length
	initial begin
		#200000;
		bad_count++;
		final_report();
	end
	// ----------------------------
	// Test sequence
	// ----------------------------
	initial begin
		void'($urandom(32'h60eb));
		foreach (m_reg[i]) m_reg[i] = 8'h00;
		m_st = 5'h18;
		repeat (2) @(posedge REF_CLK);
		#1 RST_B = 1'b1;
		for (int i = 0; i < 16; i++) chk_rd(12'(i));
		$display("reset values done");
		step(5, 8'h0f, 8'h01, 12'h009, 12'h283);
		step(9, 8'h00, 8'h00, 12'h003, 12'h083);
		step(0, 8'h00, 8'hff, 12'h183, 12'h003);
		step(5, 8'hf0, 8'h20, 12'h003, 12'h003);
		step(6, 8'h05, 8'h06, 12'h004, 12'h003);
		step(6, 8'h06, 8'h05, 12'h004, 12'h003);
		step(7, 8'h80, 8'h80, 12'h005, 12'h085);
		step(8, 8'h01, 8'h01, 12'h006, 12'h886);
		step(0, 8'h00, 8'h5a, 12'h00c, 12'h00c);
		$display("directed flags done");
		ev(1'b0, 1'b0, 1'b1);
		ev(1'b1, 1'b0, 1'b0);
		ev(1'b0, 1'b1, 1'b0);
		ev(1'b1, 1'b0, 1'b1);
		ev(1'b1, 1'b1, 1'b0);
		$display("power flags done");
		// Frozen edge: an operation and an expiry offered then must both be lost
		clk_en = 1'b0;
		evt.expire = 1'b1;
		u_cpu.run_op(crb_pkg::OP_CLEAR, 8'h00, 8'h00, 12'h009);
		evt = '0;
		clk_en = 1'b1;
		`CHK("frozen result", m_res, result)
		`CHK("frozen rd_data", {3'h0, m_st}, rd_data)
		chk_rd(12'h089);
		$display("clock enable freeze done");
		for (int i = 0; i < 64; i++) begin
			op = $urandom % 10;
			a = 8'($urandom);
			b = (op == 7 || op == 8) ? a : 8'($urandom);
			ad = 12'($urandom);
			if (i % 4 != 0) ad[6:4] = 3'h0;
			step(op, a, b, ad, ad ^ 12'hf80);
		end
		$display("random traffic done");
		do_reset(1'b0);
		chk_rd(12'h003);
		chk_rd(12'h409);
		do_reset(1'b1);
		chk_rd(12'h083);
		$display("reset causes done");
		final_report();
	end
endmodule : crb_core_regs_tb
`default_nettype wire
